// ==== logic/pkcs_pkg.sv ====
// package: register map, source indices and select decoding for kernel clocks
package pkcs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] KSEL_OFFSET = 8'h94;
    localparam logic [DATA_W-1:0] KSEL_RESET = 32'h0000_0000;
    localparam int LPT_SEL_HI = 31;
    localparam int LPT_SEL_LO = 30;
    localparam int I2C_SEL_HI = 23;
    localparam int I2C_SEL_LO = 22;
    localparam logic [DATA_W-1:0] KSEL_RW_MASK = 32'hC0C0_0000;
    localparam logic [1:0] SEL_RESET = 2'h0;
    // positions of the candidate source clocks in the source vector
    localparam int SRC_N = 5;
    localparam int SRC_APB = 0;
    localparam int SRC_SYS = 1;
    localparam int SRC_HSI = 2;
    localparam int SRC_LSI = 3;
    localparam int SRC_LSE = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic wr;
        logic rd;
    } pkcs_bus_req_type;

    // low-power timer: 00 apb, 01 internal high-speed rc, 10 low rc, 11 ext
    function automatic int lpt_src_index(input logic [1:0] sel);
        case (sel)
            2'h1: lpt_src_index = SRC_HSI;
            2'h2: lpt_src_index = SRC_LSI;
            2'h3: lpt_src_index = SRC_LSE;
            default: lpt_src_index = SRC_APB;
        endcase
    endfunction : lpt_src_index

    // fourth i2c: 00 and 11 apb, 01 system clock, 10 internal high-speed rc
    function automatic int i2c_src_index(input logic [1:0] sel);
        case (sel)
            2'h1: i2c_src_index = SRC_SYS;
            2'h2: i2c_src_index = SRC_HSI;
            default: i2c_src_index = SRC_APB;
        endcase
    endfunction : i2c_src_index
endpackage : pkcs_pkg

// ==== logic/pkcs_clk_mux.sv ====
// kernel clock multiplexers with registered outputs
`timescale 1ns/1ps
module pkcs_clk_mux
    import pkcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [pkcs_pkg::SRC_N-1:0] src_sync,
    input wire logic [1:0] lpt_sel,
    input wire logic [1:0] i2c_sel,
    output logic lpt_kclk,
    output logic i2c_kclk
);
    logic lpt_kclk_next;
    logic i2c_kclk_next;

    // select follows the field at once, no peripheral reset needed
    always_comb begin
        lpt_kclk_next = src_sync[lpt_src_index(lpt_sel)];
        i2c_kclk_next = src_sync[i2c_src_index(i2c_sel)];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lpt_kclk <= 1'b0;
            i2c_kclk <= 1'b0;
        end else begin
            lpt_kclk <= lpt_kclk_next;
            i2c_kclk <= i2c_kclk_next;
        end
    end
endmodule : pkcs_clk_mux

// ==== logic/pkcs_kernel_clk_sel.sv ====
// kernel clock selection register and source routing for timer and i2c
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module pkcs_kernel_clk_sel
    import pkcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire pkcs_pkg::pkcs_bus_req_type bus_req,
    output logic [pkcs_pkg::DATA_W-1:0] rdata,
    input wire logic apb_clk_in,
    input wire logic sys_clk_in,
    input wire logic internal_highspeed_rc_clock,
    input wire logic internal_lowspeed_rc_clock,
    input wire logic external_lowspeed_clock,
    output logic low_power_timer_one_kclk,
    output logic fourth_i2c_controller_kclk,
    output logic [1:0] lowpower_timer_clk_select,
    output logic [1:0] fourth_i2c_kernel_clk_select
);
    import pkcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // source synchronisers
    logic [SRC_N-1:0] src_raw;
    logic [SRC_N-1:0] src_meta_reg;
    logic [SRC_N-1:0] src_sync_reg;
    logic [SRC_N-1:0] src_meta_next;
    logic [SRC_N-1:0] src_sync_next;

    assign src_raw[SRC_APB] = apb_clk_in;
    assign src_raw[SRC_SYS] = sys_clk_in;
    assign src_raw[SRC_HSI] = internal_highspeed_rc_clock;
    assign src_raw[SRC_LSI] = internal_lowspeed_rc_clock;
    assign src_raw[SRC_LSE] = external_lowspeed_clock;

    // sources are sampled levels, so only those well below ref_clk/2 survive
    genvar gi;
    generate
        for (gi = 0; gi < SRC_N; gi++) begin : g_sync
            always_comb begin
                src_meta_next[gi] = src_raw[gi];
                src_sync_next[gi] = src_meta_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
        end else begin
            src_meta_reg <= src_meta_next;
            src_sync_reg <= src_sync_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selection register
    logic [1:0] lpt_sel_reg;
    logic [1:0] lpt_sel_next;
    logic [1:0] i2c_sel_reg;
    logic [1:0] i2c_sel_next;
    logic hit;

    // only one word is mapped, so the decode is a plain compare
    assign hit = (bus_req.addr == KSEL_OFFSET);

    // each field lives in one byte lane, so partial writes touch only it
    always_comb begin
        lpt_sel_next = lpt_sel_reg;
        i2c_sel_next = i2c_sel_reg;
        if (bus_req.wr && hit && bus_req.wstrb[3]) begin
            lpt_sel_next = bus_req.wdata[LPT_SEL_HI:LPT_SEL_LO];
        end
        if (bus_req.wr && hit && bus_req.wstrb[2]) begin
            i2c_sel_next = bus_req.wdata[I2C_SEL_HI:I2C_SEL_LO];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lpt_sel_reg <= SEL_RESET;
            i2c_sel_reg <= SEL_RESET;
        end else begin
            lpt_sel_reg <= lpt_sel_next;
            i2c_sel_reg <= i2c_sel_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe, zero otherwise
    logic [DATA_W-1:0] rdata_next;
    logic [DATA_W-1:0] ksel_word;
    logic [1:0] lpt_out_next;
    logic [1:0] i2c_out_next;

    // reserved bits are not stored, so they read zero whatever was written
    always_comb begin
        ksel_word = KSEL_RESET;
        ksel_word[LPT_SEL_HI:LPT_SEL_LO] = lpt_sel_reg;
        ksel_word[I2C_SEL_HI:I2C_SEL_LO] = i2c_sel_reg;
        rdata_next = '0;
        if (bus_req.rd && hit) begin
            rdata_next = ksel_word & KSEL_RW_MASK;
        end
        lpt_out_next = lpt_sel_next;
        i2c_out_next = i2c_sel_next;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= '0;
            lowpower_timer_clk_select <= SEL_RESET;
            fourth_i2c_kernel_clk_select <= SEL_RESET;
        end else begin
            rdata <= rdata_next;
            lowpower_timer_clk_select <= lpt_out_next;
            fourth_i2c_kernel_clk_select <= i2c_out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // kernel clock multiplexers
    pkcs_clk_mux u_mux (
        .ref_clk(ref_clk),
        .rst(rst),
        .src_sync(src_sync_reg),
        .lpt_sel(lpt_sel_reg),
        .i2c_sel(i2c_sel_reg),
        .lpt_kclk(low_power_timer_one_kclk),
        .i2c_kclk(fourth_i2c_controller_kclk)
    );

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // all checks run on ref_clk and sleep while reset is high
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // the mux adds one register, so kernel outputs lag the synced source
    a_lpt_route: assert property (
        low_power_timer_one_kclk ==
            $past(src_sync_reg[lpt_src_index(lpt_sel_reg)])
    ) else $error("timer kernel clock not from selected source");

    a_i2c_route: assert property (
        fourth_i2c_controller_kclk ==
            $past(src_sync_reg[i2c_src_index(i2c_sel_reg)])
    ) else $error("i2c kernel clock not from selected source");

    a_reset_zero: assert property (
        $past(rst) |-> (lpt_sel_reg == 2'h0 && i2c_sel_reg == 2'h0)
    ) else $error("select fields not zero after reset");

    a_byte_write: assert property (
        (bus_req.wr && hit && bus_req.wstrb[2] && !bus_req.wstrb[3])
        |=> (i2c_sel_reg == $past(bus_req.wdata[23:22])
             && lpt_sel_reg == $past(lpt_sel_reg))
    ) else $error("byte lane write touched wrong field");

    a_read_back: assert property (
        (bus_req.rd && hit) |=>
            (rdata[31:30] == $past(lpt_sel_reg)
             && rdata[23:22] == $past(i2c_sel_reg)
             && (rdata & 32'h3F3F_FFFF) == 32'h0000_0000)
    ) else $error("read back differs from stored fields");

    a_sel_follows: assert property (
        (bus_req.wr && hit && bus_req.wstrb[3]) |=>
            lowpower_timer_clk_select == $past(bus_req.wdata[31:30])
            ##1 low_power_timer_one_kclk ==
                $past(src_sync_reg[lpt_src_index(lpt_sel_reg)])
    ) else $error("timer select did not act after write");

    a_i2c_follows: assert property (
        (bus_req.wr && hit && bus_req.wstrb[2]) |=>
            fourth_i2c_kernel_clk_select ==
                $past(bus_req.wdata[I2C_SEL_HI:I2C_SEL_LO])
    ) else $error("i2c select did not act after write");

    // lane 3 alone must leave the i2c field where it was
    a_lane3_write: assert property (
        (bus_req.wr && hit && bus_req.wstrb[3] && !bus_req.wstrb[2])
        |=> (lpt_sel_reg == $past(bus_req.wdata[LPT_SEL_HI:LPT_SEL_LO])
             && i2c_sel_reg == $past(i2c_sel_reg))
    ) else $error("lane three write touched wrong field");

    // unmapped writes and writes on lanes 0 and 1 must change nothing
    a_fields_hold: assert property (
        !(bus_req.wr && hit && (bus_req.wstrb[3] || bus_req.wstrb[2]))
        |=> (lpt_sel_reg == $past(lpt_sel_reg)
             && i2c_sel_reg == $past(i2c_sel_reg))
    ) else $error("select field changed without a write");

    // the select outputs are software's view of what the muxes use
    a_sel_outputs: assert property (
        lowpower_timer_clk_select == lpt_sel_reg
        && fourth_i2c_kernel_clk_select == i2c_sel_reg
    ) else $error("select outputs differ from stored fields");

    // a stale word must not linger on the read port
    a_rdata_idle: assert property (
        !(bus_req.rd && hit) |=> (rdata == '0)
    ) else $error("read data not zero outside a read");

    a_kclk_reset: assert property (
        $past(rst) |-> (!low_power_timer_one_kclk
                        && !fourth_i2c_controller_kclk)
    ) else $error("kernel clocks not low after reset");

    c_lpt_lse: cover property (lpt_sel_reg == 2'h3);
    c_i2c_sys: cover property (i2c_sel_reg == 2'h1);
    c_write_read: cover property ((bus_req.wr && hit) ##1 (bus_req.rd && hit));
    c_byte_lane: cover property (bus_req.wr && hit && bus_req.wstrb == 4'h4);
    c_unmapped_rd: cover property (bus_req.rd && !hit);
endmodule : pkcs_kernel_clk_sel

// ==== test/pkcs_kernel_clk_sel_test.sv ====
// self-checking bench for the kernel clock selection register and muxes
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("[FAIL] %s exp %h got %h", nm, exp, got); \
    end \
end
module pkcs_kernel_clk_sel_test;
    import pkcs_pkg::*;
    typedef struct {
        logic [31:0] wdata;
        logic [31:0] rb;
        int li;
        int ii;
    } pkcs_row_type;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    pkcs_bus_req_type bus_req = '0;
    logic [31:0] rdata;
    logic [4:0] src = 5'h0;
    logic lpt_k;
    logic i2c_k;
    logic [1:0] lpt_s;
    logic [1:0] i2c_s;
    int num_errors = 0;
    int checks_done = 0;
    // three patterns give every source its own on/off sequence
    logic [4:0] pat [3] = '{5'h15, 5'h06, 5'h18};
    // every code of both fields; software keeps reserved bits at zero
    pkcs_row_type rows [4] = '{
        '{32'hC0C0_0000, 32'hC0C0_0000, SRC_LSE, SRC_APB},
        '{32'h4040_0000, 32'h4040_0000, SRC_HSI, SRC_SYS},
        '{32'h8080_0000, 32'h8080_0000, SRC_LSI, SRC_HSI},
        '{32'h0000_0000, 32'h0000_0000, SRC_APB, SRC_APB}};

    pkcs_kernel_clk_sel dut_u (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus_req(bus_req),
        .rdata(rdata),
        .apb_clk_in(src[SRC_APB]),
        .sys_clk_in(src[SRC_SYS]),
        .internal_highspeed_rc_clock(src[SRC_HSI]),
        .internal_lowspeed_rc_clock(src[SRC_LSI]),
        .external_lowspeed_clock(src[SRC_LSE]),
        .low_power_timer_one_kclk(lpt_k),
        .fourth_i2c_controller_kclk(i2c_k),
        .lowpower_timer_clk_select(lpt_s),
        .fourth_i2c_kernel_clk_select(i2c_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    // one bus cycle; returns just after the edge that takes it
    task bus(input logic w, input logic r, input logic [7:0] a,
             input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wstrb: s, wr: w, rd: r};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        #1;
    endtask : bus

    // read data is only valid in the single cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, 1'b1, a, 32'h0000_0000, 4'h0);
        `CHK("rdata", exp, rdata)
    endtask : rd_chk

    task stop_test;
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the whole run needs well under 500 cycles
    initial begin
        #(40 * 3000);
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        `CHK("lpt_sel_rst", 2'h0, lpt_s)
        `CHK("i2c_sel_rst", 2'h0, i2c_s)
        rd_chk(KSEL_OFFSET, 32'h0000_0000);
        // table rows: write, selects, readback, then routing of each source
        foreach (rows[i]) begin
            bus(1'b1, 1'b0, KSEL_OFFSET, rows[i].wdata, 4'hF);
            `CHK("lpt_sel", rows[i].rb[31:30], lpt_s)
            `CHK("i2c_sel", rows[i].rb[23:22], i2c_s)
            rd_chk(KSEL_OFFSET, rows[i].rb);
            foreach (pat[p]) begin
                @(posedge ref_clk);
                src <= pat[p];
                repeat (3) @(posedge ref_clk);
                #1;
                `CHK("lpt_kclk", pat[p][rows[i].li], lpt_k)
                `CHK("i2c_kclk", pat[p][rows[i].ii], i2c_k)
            end
        end
        // byte lanes: lane 3 then lane 2 alone, lanes 0 and 1 change nothing
        bus(1'b1, 1'b0, KSEL_OFFSET, 32'h8000_0000, 4'b1000);
        bus(1'b1, 1'b0, KSEL_OFFSET, 32'h00C0_0000, 4'b0100);
        bus(1'b1, 1'b0, KSEL_OFFSET, 32'hC0C0_0000, 4'b0011);
        rd_chk(KSEL_OFFSET, 32'h80C0_0000);
        // unmapped place ignored; back-to-back read right after the write
        @(posedge ref_clk);
        bus_req <= '{addr: 8'h90, wdata: 32'h0, wstrb: 4'hF, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '{addr: KSEL_OFFSET, wdata: 32'h0, wstrb: 4'h0, wr: 1'b0,
                     rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        `CHK("rdata_b2b", 32'h80C0_0000, rdata)
        @(posedge ref_clk);
        #1;
        `CHK("rdata_idle", 32'h0000_0000, rdata)
        rd_chk(8'h90, 32'h0000_0000);
        // reset in mid-run clears the fields again
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        `CHK("lpt_sel_rst2", 2'h0, lpt_s)
        `CHK("i2c_sel_rst2", 2'h0, i2c_s)
        rd_chk(KSEL_OFFSET, 32'h0000_0000);
        stop_test();
    end
endmodule : pkcs_kernel_clk_sel_test
